// [design/hdsts_pkg.sv]
// Constants shared by the receive data-link event status block.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
package hdsts_pkg;

    // ==========================================================
    // Register indices and byte addresses
    // ==========================================================
    localparam logic [15:0] HDSTS_STATUS_IDX = 16'h0b26;
    localparam logic [15:0] HDSTS_ENABLE_IDX = 16'h0b27;
    localparam logic [15:0] HDSTS_CLEAR_IDX  = 16'h0b2a;
    localparam int          HDSTS_ADDR_W     = 16;
    localparam logic [15:0] HDSTS_STATUS_ADDR = 16'((32'(HDSTS_STATUS_IDX)) << 2);
    localparam logic [15:0] HDSTS_ENABLE_ADDR = 16'((32'(HDSTS_ENABLE_IDX)) << 2);
    localparam logic [15:0] HDSTS_CLEAR_ADDR  = 16'((32'(HDSTS_CLEAR_IDX)) << 2);

    // ==========================================================
    // Field layout and reset values
    // ==========================================================
    localparam int          HDSTS_NFLAGS       = 4;
    localparam int          HDSTS_BIT_FLAG_OCT = 0;
    localparam int          HDSTS_BIT_ABORT    = 1;
    localparam int          HDSTS_BIT_CHECK    = 2;
    localparam int          HDSTS_BIT_MSG_END  = 3;
    localparam logic [3:0]  HDSTS_STATUS_RST   = 4'h0;
    localparam logic [3:0]  HDSTS_ENABLE_RST   = 4'h0;

    // ==========================================================
    // Bit stream patterns
    // ==========================================================
    localparam logic [7:0]  HDSTS_FLAG_OCTET   = 8'h7e;
    localparam logic [2:0]  HDSTS_ABORT_ONES   = 3'h7;

    // ==========================================================
    // Bus answers
    // ==========================================================
    localparam logic [1:0]  HDSTS_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  HDSTS_RESP_SLVERR  = 2'h2;

endpackage

// [design/hdsts_bit_watch.sv]
// Watches the synchronised data-link bit stream for flag octets and aborts.
// Assumes one bit strobe per bit, from logic on the same clock.
module hdsts_bit_watch
    import hdsts_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Bit stream
    input  wire logic bit_take,
    input  wire logic bit_value,
    // Detections, one-cycle pulses
    output logic      flag_seen,
    output logic      abort_seen
);

    logic [7:0] window;
    logic [2:0] ones;
    logic [7:0] next_window;
    logic [2:0] next_ones;
    logic       next_flag_seen;
    logic       next_abort_seen;

    always_comb begin
        next_window     = window;
        next_ones       = ones;
        next_flag_seen  = 1'b0;
        next_abort_seen = 1'b0;
        if (bit_take) begin
            next_window = {bit_value, window[7:1]};
            next_flag_seen = (next_window == HDSTS_FLAG_OCTET);
            if (!bit_value) begin
                next_ones = 3'h0;
            end else if (ones != HDSTS_ABORT_ONES) begin
                next_ones = ones + 3'h1;
            end
            // Fires once when the seventh one arrives, not on every further one.
            next_abort_seen = bit_value && (ones == HDSTS_ABORT_ONES - 3'h1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            window     <= 8'h00;
            ones       <= 3'h0;
            flag_seen  <= 1'b0;
            abort_seen <= 1'b0;
        end else begin
            window     <= next_window;
            ones       <= next_ones;
            flag_seen  <= next_flag_seen;
            abort_seen <= next_abort_seen;
        end
    end

endmodule

// [design/hdsts_top.sv]
// Receive data-link event status for the third receive link controller.
// Assumes an AXI4-Lite master on aclk, controller events on aclk and the
// data-link bit stream arriving asynchronously on pins.
module hdsts_top
    import hdsts_pkg::*;
(
    // Clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // Data-link pins
    input  wire logic                      rx_dl_bit,
    input  wire logic                      rx_dl_strobe,
    // Receive controller events, one-cycle pulses
    input  wire logic                      rx_msg_done,
    input  wire logic                      rx_buf_full,
    input  wire logic                      rx_fcs_fail,
    // AXI4-Lite write address and data
    input  wire logic [hdsts_pkg::HDSTS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // AXI4-Lite read
    input  wire logic [hdsts_pkg::HDSTS_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // Interrupt
    output logic                           irq
);
    import hdsts_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] bit_sync;
    logic [1:0] strobe_sync;
    logic       strobe_last;
    logic       bit_take;
    logic       flag_seen;
    logic       abort_seen;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_sync    <= 2'h0;
            strobe_sync <= 2'h0;
            strobe_last <= 1'b0;
        end else begin
            bit_sync    <= {bit_sync[0], rx_dl_bit};
            strobe_sync <= {strobe_sync[0], rx_dl_strobe};
            strobe_last <= strobe_sync[1];
        end
    end

    // The data bit has settled long before the strobe edge, so sampling the
    // synchronised copy on the synchronised rising edge is safe.
    assign bit_take = strobe_sync[1] && !strobe_last;

    hdsts_bit_watch u_watch (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .bit_take   (bit_take),
        .bit_value  (bit_sync[1]),
        .flag_seen  (flag_seen),
        .abort_seen (abort_seen)
    );

    // ==========================================================
    // Register state
    // ==========================================================
    logic [HDSTS_NFLAGS-1:0] status;
    logic [HDSTS_NFLAGS-1:0] enable;
    logic [HDSTS_NFLAGS-1:0] events;
    logic [HDSTS_NFLAGS-1:0] clear_bits;
    logic [HDSTS_NFLAGS-1:0] next_status;
    logic [HDSTS_NFLAGS-1:0] next_enable;
    logic                    next_irq;

    always_comb begin
        events                     = '0;
        events[HDSTS_BIT_MSG_END]  = rx_msg_done || rx_buf_full;
        events[HDSTS_BIT_CHECK]    = rx_fcs_fail;
        events[HDSTS_BIT_ABORT]    = abort_seen;
        events[HDSTS_BIT_FLAG_OCT] = flag_seen;
    end

    // ==========================================================
    // AXI4-Lite write channel
    // ==========================================================
    logic                    aw_held;
    logic                    w_held;
    logic [HDSTS_ADDR_W-1:0] aw_addr;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    next_aw_held;
    logic                    next_w_held;
    logic [HDSTS_ADDR_W-1:0] next_aw_addr;
    logic [31:0]             next_w_data;
    logic [3:0]              next_w_strb;
    logic                    next_awready;
    logic                    next_wready;
    logic                    next_bvalid;
    logic [1:0]              next_bresp;
    logic                    do_write;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_enable  = enable;
        clear_bits   = '0;
        do_write     = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            do_write     = 1'b1;
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = HDSTS_RESP_OKAY;
            case (aw_addr)
                HDSTS_STATUS_ADDR,
                HDSTS_CLEAR_ADDR: begin
                    if (w_strb[0]) begin
                        clear_bits = w_data[HDSTS_NFLAGS-1:0];
                    end
                end
                HDSTS_ENABLE_ADDR: begin
                    if (w_strb[0]) begin
                        next_enable = w_data[HDSTS_NFLAGS-1:0];
                    end
                end
                default: begin
                    next_bresp = HDSTS_RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_held && !do_write;
        next_wready  = !next_w_held && !do_write;
    end

    // ==========================================================
    // AXI4-Lite read channel
    // ==========================================================
    logic                    next_arready;
    logic                    next_rvalid;
    logic [31:0]             next_rdata;
    logic [1:0]              next_rresp;
    logic [HDSTS_NFLAGS-1:0] read_clear;

    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        read_clear  = '0;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = 32'h0;
            next_rresp  = HDSTS_RESP_OKAY;
            case (s_axi_araddr)
                HDSTS_STATUS_ADDR: begin
                    next_rdata[HDSTS_NFLAGS-1:0] = status;
                    read_clear = status;
                end
                HDSTS_ENABLE_ADDR: begin
                    next_rdata[HDSTS_NFLAGS-1:0] = enable;
                end
                HDSTS_CLEAR_ADDR: begin
                    next_rdata = 32'h0;
                end
                default: begin
                    next_rresp = HDSTS_RESP_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    // ==========================================================
    // Sticky flags and interrupt
    // ==========================================================
    // A new event in the clearing cycle survives, so no event is lost in the
    // cycle of a clearing read or write; a later write still clears it unread.
    always_comb begin
        next_status = (status & ~(clear_bits | read_clear)) | events;
        next_irq    = |(next_status & next_enable);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status        <= HDSTS_STATUS_RST;
            enable        <= HDSTS_ENABLE_RST;
            irq           <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= HDSTS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= HDSTS_RESP_OKAY;
        end else begin
            status        <= next_status;
            enable        <= next_enable;
            irq           <= next_irq;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

endmodule

// [testbench/hdsts_monitor.sv]
// Checker for the event status block, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
module hdsts_monitor (
    // Clock, reset and interrupt
    input wire logic                               aclk,
    input wire logic                               aresetn,
    input wire logic                               irq,
    // Bus handshakes
    input wire logic                               s_axi_awready,
    input wire logic                               s_axi_wready,
    input wire logic                               s_axi_bvalid,
    input wire logic                               s_axi_bready,
    input wire logic                               s_axi_arvalid,
    input wire logic                               s_axi_arready,
    input wire logic                               s_axi_rvalid,
    input wire logic                               s_axi_rready,
    // Bus payloads
    input wire logic [hdsts_pkg::HDSTS_ADDR_W-1:0] s_axi_araddr,
    input wire logic [31:0]                        s_axi_rdata,
    input wire logic [1:0]                         s_axi_bresp,
    input wire logic [1:0]                         s_axi_rresp
);
    import hdsts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic unmapped;
    assign unmapped = s_axi_araddr != HDSTS_STATUS_ADDR && s_axi_araddr != HDSTS_ENABLE_ADDR
        && s_axi_araddr != HDSTS_CLEAR_ADDR;
    property p_quiet; $rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid; endproperty
    a_quiet: assert property (p_quiet) else $error("output active after reset");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer not held");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer not held");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_arref; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arref: assert property (p_arref) else $error("address taken while busy");
    property p_unmap; s_axi_arvalid && s_axi_arready && unmapped
        |=> s_axi_rresp == HDSTS_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read answered");
    property p_bafter;
        $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
    endproperty
    a_bafter: assert property (p_bafter) else $error("write answer too early");
    property p_rdhi; s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0; endproperty
    a_rdhi: assert property (p_rdhi) else $error("unused bits read nonzero");
endmodule

// [testbench/hdsts_host_model.sv]
// Host model: a register bus master offering write and read as tasks.
// Assumes the top module testbench holds errors and close_out.
module hdsts_host_model (
    // Clock
    input wire logic                           aclk,
    // Requests
    output logic [hdsts_pkg::HDSTS_ADDR_W-1:0] s_axi_awaddr,
    output logic [hdsts_pkg::HDSTS_ADDR_W-1:0] s_axi_araddr,
    output logic [31:0]                        s_axi_wdata,
    output logic [3:0]                         s_axi_wstrb,
    output logic                               s_axi_awvalid,
    output logic                               s_axi_wvalid,
    output logic                               s_axi_bready,
    output logic                               s_axi_arvalid,
    output logic                               s_axi_rready,
    // Answers
    input wire logic                           s_axi_awready,
    input wire logic                           s_axi_wready,
    input wire logic                           s_axi_bvalid,
    input wire logic                           s_axi_arready,
    input wire logic                           s_axi_rvalid,
    input wire logic [1:0]                     s_axi_bresp,
    input wire logic [1:0]                     s_axi_rresp,
    input wire logic [31:0]                    s_axi_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
        s_axi_wstrb = 4'hf;
    end
    task automatic timeout();
        testbench.errors = testbench.errors + 1;
        testbench.close_out();
    endtask
    // Each channel is released only at the edge that takes it.
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        bit got = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                got = 1'b1;
                s_axi_bready <= 1'b0;
            end
        end
        if (!got) timeout();
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        bit got = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                got = 1'b1;
                s_axi_rready <= 1'b0;
            end
        end
        if (!got) timeout();
    endtask
endmodule

// [testbench/hdsts_testbench.sv]
// Self-checking bench for the receive data-link event status block.
// Assumes the host model and the checker are compiled alongside.
module testbench;
    import hdsts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, irq, rx_dl_bit = 1'b0, rx_dl_strobe = 1'b0;
    logic rx_msg_done = 1'b0, rx_buf_full = 1'b0, rx_fcs_fail = 1'b0;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int errors = 0, checks_done = 0;
    always #20 aclk = ~aclk;
    hdsts_top uut (.*);
    hdsts_host_model host (.*);
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] e);
        host.rd(a, rv, rr);
        chk(nm, rv, e);
        chk("rresp", 32'(rr), 32'(HDSTS_RESP_OKAY));
    endtask
    task automatic wrc(input logic [15:0] a, input logic [31:0] d);
        host.wr(a, d, 4'hf, rr);
        chk("bresp", 32'(rr), 32'(HDSTS_RESP_OKAY));
    endtask
    task automatic ev(input logic [2:0] m);
        @(posedge aclk);
        {rx_msg_done, rx_buf_full, rx_fcs_fail} <= m;
        @(posedge aclk);
        {rx_msg_done, rx_buf_full, rx_fcs_fail} <= 3'h0;
    endtask
    // Levels are held three cycles so the pin synchronisers never miss an edge.
    task automatic send(input logic [7:0] bits);
        for (int i = 0; i < 8; i++) begin
            repeat (3) @(posedge aclk);
            rx_dl_strobe <= 1'b0;
            rx_dl_bit <= bits[i];
            repeat (3) @(posedge aclk);
            rx_dl_strobe <= 1'b1;
        end
        repeat (3) @(posedge aclk);
        rx_dl_strobe <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge aclk);
        chk("irq", 32'(irq), 32'(e));
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_ctrl();
        rdc("status", HDSTS_STATUS_ADDR, 32'h0);
        ev(3'b100);
        rdc("end", HDSTS_STATUS_ADDR, 32'h8);
        rdc("cleared", HDSTS_STATUS_ADDR, 32'h0);
        ev(3'b010);
        rdc("full", HDSTS_STATUS_ADDR, 32'h8);
        ev(3'b001);
        rdc("check", HDSTS_STATUS_ADDR, 32'h4);
    endtask
    task automatic t_pins();
        ev(3'b100);
        send(8'h7e);
        rdc("whole", HDSTS_STATUS_ADDR, 32'h9);
        send(8'hff);
        rdc("abort", HDSTS_STATUS_ADDR, 32'h2);
        send(8'h7e);
        rdc("flag", HDSTS_STATUS_ADDR, 32'h1);
    endtask
    task automatic t_irq();
        irq_is(1'b0);
        wrc(HDSTS_ENABLE_ADDR, 32'hffff_fff8);
        rdc("enable", HDSTS_ENABLE_ADDR, 32'h8);
        host.wr(HDSTS_ENABLE_ADDR, 32'h0, 4'he, rr);
        rdc("enable lane", HDSTS_ENABLE_ADDR, 32'h8);
        ev(3'b001);
        irq_is(1'b0);
        ev(3'b100);
        irq_is(1'b1);
        wrc(HDSTS_STATUS_ADDR, 32'h4);
        rdc("w1c", HDSTS_STATUS_ADDR, 32'h8);
        irq_is(1'b0);
        ev(3'b100);
        wrc(HDSTS_CLEAR_ADDR, 32'h8);
        irq_is(1'b0);
        rdc("clr", HDSTS_CLEAR_ADDR, 32'h0);
    endtask
    task automatic t_map();
        host.rd(16'h0000, rv, rr);
        chk("unmapped rresp", 32'(rr), 32'(HDSTS_RESP_SLVERR));
        host.wr(16'h0004, 32'hf, 4'hf, rr);
        chk("unmapped bresp", 32'(rr), 32'(HDSTS_RESP_SLVERR));
    endtask
    task automatic t_rerun();
        ev(3'b100);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdc("status rst", HDSTS_STATUS_ADDR, 32'h0);
        rdc("enable rst", HDSTS_ENABLE_ADDR, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_ctrl();
        t_pins();
        t_irq();
        t_map();
        t_rerun();
        close_out();
    end
endmodule
bind hdsts_top hdsts_monitor u_mon (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .irq           (irq),
    .s_axi_awready (s_axi_awready),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_rresp   (s_axi_rresp)
);
